// ### verilog/rsf_pkg.sv
// Constants for the receiver status read-out bank: read addresses,
// lower-byte field positions, rate windows and reference-tick timing.
// Assumes a single 20 MHz core clock and a synchronous reset.
`default_nettype none

package rsf_pkg;

	// ------------------------------------------------------------
	// Read addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_STREAM_STATUS = 8'hEA;
	localparam logic [7:0] ADDR_PIN_RATE      = 8'hEB;

	// ------------------------------------------------------------
	// Lower byte of the stream status word
	// ------------------------------------------------------------
	localparam int BIT_ERROR  = 0;
	localparam int BIT_INDET  = 1;
	localparam int BIT_FSCHG  = 2;
	localparam int BIT_CSRNW  = 3;
	localparam int BIT_NONPCM = 4;
	localparam int BIT_PCRNW  = 5;
	localparam int BIT_SLIP   = 6;
	localparam int BIT_EMPH   = 7;
	localparam int CHG_W      = 5;

	// Change flag slots: 0 input pin, 1 rate, 2 chan status, 3 burst info, 4 slip
	localparam int CHG_INDET  = 0;
	localparam int CHG_FSCHG  = 1;
	localparam int CHG_CSRNW  = 2;
	localparam int CHG_PCRNW  = 3;
	localparam int CHG_SLIP   = 4;

	// ------------------------------------------------------------
	// Reference tick and rate measurement
	// ------------------------------------------------------------
	localparam int CORE_CLK_KHZ = 20000;
	localparam int REF_CLK_KHZ  = 6144;
	localparam int ACC_W        = 15;
	// Rate numerator in 100 Hz units: rate = RATE_NUM / count
	localparam int RATE_NUM     = 61440;
	localparam int FRM_W        = 13;
	localparam logic [3:0] CODE_OUT_OF_RANGE = 4'h0;
	localparam logic [3:0] CODE_FIRST        = 4'h4;
	localparam int NUM_RATES    = 12;
	// Windows in 100 Hz units, 16 kHz upward
	localparam int WIN_LO [NUM_RATES] = '{154, 212, 231, 308, 424, 462,
		615, 854, 931, 1229, 1707, 1862};
	localparam int WIN_HI [NUM_RATES] = '{166, 229, 249, 333, 458, 499,
		667, 917, 1007, 1335, 1807, 1981};

endpackage

`default_nettype wire

// ### verilog/rsf_status_bank.sv
// Read-only status bank of the audio receiver: stream detection flags,
// general-purpose input levels, coded and raw input sampling rate.
// Assumes demodulator strobes on the core clock; pins are asynchronous.
`default_nettype none

// Overview of operation
// R1 - Error and non-PCM bits read the source picked by their own selects, whatever the interrupt pin does.
// R2 - Address 0xEA upper byte holds non-PCM, burst, sync, extended sync, then 512/1024/2048/4096 flags.
// R3 - The channel-status non-PCM flag reads 0 for PCM and 1 for non-PCM.
// R4 - The burst flag reads 1 while both burst sync words are detected.
// R5 - The first surround sync flag reads 1 while its sync pattern is detected.
// R6 - The extended surround sync flag reads 1 while its sync pattern is detected.
// R7 - The 1024 flag reads 1 when the sync interval is 1024 or 2048 frames.
// R8 - The 512, 2048 and 4096 flags match their count or its double, 4096 matching only itself.
// R9 - Address 0xEB bits 3..0 read the sampled general-purpose pins set as inputs.
// R10 - Address 0xEB bits 7..4 read the coded sampling rate, 0 meaning out of range.
// R11 - A rate code is given only inside its window, otherwise the out-of-range code.
// R12 - Address 0xEB bits 15..8 read the 8-bit rate counter, LSB at bit 8.
// R13 - The counter value is 6144 divided by the rate in kHz.
// R14 - The counter is stepped by a 6.144 MHz reference tick.
// R15 - Counts at rates below 24 kHz saturate and are not valid.
// R16 - Change flags in the 0xEA lower byte clear once read.
// R17 - The host sets the read address first and then takes the returned 24-bit word one cycle later.
module rsf_status_bank (
	input  wire logic                       core_clk_in,
	input  wire logic                       sys_rst_in,
	input  wire logic [7:0]                 rd_addr_in,
	input  wire logic                       rd_req_in,
	input  wire logic [1:0]                 receive_error_signal_in,
	input  wire logic                       error_source_select_in,
	input  wire logic [1:0]                 audio_indication_in,
	input  wire logic                       audio_flag_source_select_in,
	input  wire logic                       emphasis_in,
	input  wire logic [3:0]                 change_event_in,
	input  wire logic                       chan_status_nonpcm_flag_in,
	input  wire logic                       burst_preamble_flag_in,
	input  wire logic                       surround_sync_flag_in,
	input  wire logic                       extended_surround_sync_flag_in,
	input  wire logic                       frame_start_in,
	input  wire logic                       sync_found_in,
	input  wire logic                       fs_clk_in,
	input  wire logic [3:0]                 gp_pin_in,
	input  wire logic [3:0]                 gp_pin_is_input_in,
	output logic      [23:0]                rd_data_out,
	output logic                            rd_valid_out
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0]                       gp_s1;
		logic [3:0]                       gp_s2;
		logic                             fs_prev;
		logic [rsf_pkg::ACC_W-1:0]        acc;
		logic                             ref_tick;
		logic [7:0]                       cnt;
		logic                             cnt_sat;
		logic [7:0]                       rate_val;
		logic                             rate_sat;
		logic [3:0]                       rate_code;
		logic [rsf_pkg::FRM_W-1:0]        frm_cnt;
		logic [rsf_pkg::FRM_W-1:0]        interval;
		logic [rsf_pkg::CHG_W-1:0]        chg;
		logic [23:0]                      rd_data;
		logic                             rd_valid;
	} rsf_state_t;

	rsf_state_t s_q;
	rsf_state_t s_d;

	// ------------------------------------------------------------
	// Rate window lookup
	// ------------------------------------------------------------
	function automatic logic [3:0] rsf_rate_code(input logic [7:0] cnt, input logic sat);
		int prod_lo;
		int prod_hi;
		logic [3:0] code;
		code = rsf_pkg::CODE_OUT_OF_RANGE;
		for (int i = 0; i < rsf_pkg::NUM_RATES; i++) begin
			prod_lo = int'(cnt) * rsf_pkg::WIN_LO[i];
			prod_hi = int'(cnt) * rsf_pkg::WIN_HI[i];
			if (!sat && cnt != 8'h00 && prod_lo <= rsf_pkg::RATE_NUM
					&& prod_hi >= rsf_pkg::RATE_NUM) begin // R11
				code = rsf_pkg::CODE_FIRST + 4'(i); // R10
			end
		end
		return code;
	endfunction

	logic [rsf_pkg::ACC_W:0]     acc_sum;
	logic                        fs_edge;
	logic [7:0]                  cnt_step;
	logic                        step_sat;
	logic [rsf_pkg::FRM_W-1:0]   frm_next;
	logic                        err_bit;
	logic                        nonpcm_bit;
	logic                        sync_any;
	logic [3:0]                  int_flags;
	logic [7:0]                  low_byte;
	logic [rsf_pkg::CHG_W-1:0]   chg_ev;
	logic [rsf_pkg::CHG_W-1:0]   chg_clr;

	always_comb begin
		s_d = s_q;
		// Pin synchroniser
		s_d.gp_s1 = gp_pin_in;
		s_d.gp_s2 = s_q.gp_s1;

		// Fractional divider: 6.144 MHz tick from the core clock
		acc_sum = {1'b0, s_q.acc} + (rsf_pkg::ACC_W+1)'(rsf_pkg::REF_CLK_KHZ);
		if (acc_sum >= (rsf_pkg::ACC_W+1)'(rsf_pkg::CORE_CLK_KHZ)) begin // R14
			s_d.acc = rsf_pkg::ACC_W'(acc_sum - (rsf_pkg::ACC_W+1)'(rsf_pkg::CORE_CLK_KHZ));
			s_d.ref_tick = 1'b1;
		end else begin
			s_d.acc = acc_sum[rsf_pkg::ACC_W-1:0];
			s_d.ref_tick = 1'b0;
		end

		// Period count of the input frame clock in reference ticks
		s_d.fs_prev = fs_clk_in;
		fs_edge = fs_clk_in && !s_q.fs_prev;
		step_sat = s_q.cnt_sat || (s_q.ref_tick && s_q.cnt == 8'hFF); // R15
		cnt_step = (s_q.ref_tick && !step_sat) ? s_q.cnt + 8'h01 : s_q.cnt; // R14
		if (fs_edge) begin
			s_d.rate_val = cnt_step; // R13
			s_d.rate_sat = step_sat;
			s_d.rate_code = rsf_rate_code(cnt_step, step_sat);
			s_d.cnt = 8'h00;
			s_d.cnt_sat = 1'b0;
		end else if (step_sat) begin
			s_d.rate_val = 8'hFF; // R15
			s_d.rate_sat = 1'b1;
			s_d.rate_code = rsf_pkg::CODE_OUT_OF_RANGE;
			s_d.cnt = cnt_step;
			s_d.cnt_sat = 1'b1;
		end else begin
			s_d.cnt = cnt_step;
			s_d.cnt_sat = 1'b0;
		end

		// Sync repetition interval in frames
		frm_next = s_q.frm_cnt;
		if (frame_start_in && s_q.frm_cnt != {rsf_pkg::FRM_W{1'b1}}) begin
			frm_next = s_q.frm_cnt + rsf_pkg::FRM_W'(1);
		end
		if (sync_found_in) begin
			s_d.interval = frm_next;
			s_d.frm_cnt = '0;
		end else begin
			s_d.frm_cnt = frm_next;
		end

		// Source selection for error and non-PCM bits
		err_bit = receive_error_signal_in[error_source_select_in]; // R1
		nonpcm_bit = audio_indication_in[audio_flag_source_select_in]; // R1

		sync_any = surround_sync_flag_in || extended_surround_sync_flag_in;
		int_flags[0] = sync_any && (s_q.interval == 13'h0200
			|| s_q.interval == 13'h0400); // R8
		int_flags[1] = sync_any && (s_q.interval == 13'h0400
			|| s_q.interval == 13'h0800); // R7
		int_flags[2] = sync_any && (s_q.interval == 13'h0800
			|| s_q.interval == 13'h1000); // R8
		int_flags[3] = sync_any && s_q.interval == 13'h1000; // R8

		// Sticky change flags, set wins over clear on read
		chg_ev = '0;
		chg_ev[rsf_pkg::CHG_INDET] = change_event_in[0];
		chg_ev[rsf_pkg::CHG_FSCHG] = s_d.rate_code != s_q.rate_code;
		chg_ev[rsf_pkg::CHG_CSRNW] = change_event_in[1];
		chg_ev[rsf_pkg::CHG_PCRNW] = change_event_in[2];
		chg_ev[rsf_pkg::CHG_SLIP] = change_event_in[3];
		chg_clr = (rd_req_in && rd_addr_in == rsf_pkg::ADDR_STREAM_STATUS)
			? {rsf_pkg::CHG_W{1'b1}} : '0;
		s_d.chg = (s_q.chg & ~chg_clr) | chg_ev; // R16

		low_byte = 8'h00;
		low_byte[rsf_pkg::BIT_ERROR] = err_bit;
		low_byte[rsf_pkg::BIT_INDET] = s_q.chg[rsf_pkg::CHG_INDET];
		low_byte[rsf_pkg::BIT_FSCHG] = s_q.chg[rsf_pkg::CHG_FSCHG];
		low_byte[rsf_pkg::BIT_CSRNW] = s_q.chg[rsf_pkg::CHG_CSRNW];
		low_byte[rsf_pkg::BIT_NONPCM] = nonpcm_bit;
		low_byte[rsf_pkg::BIT_PCRNW] = s_q.chg[rsf_pkg::CHG_PCRNW];
		low_byte[rsf_pkg::BIT_SLIP] = s_q.chg[rsf_pkg::CHG_SLIP];
		low_byte[rsf_pkg::BIT_EMPH] = emphasis_in;

		// Read answer, one cycle after the request
		s_d.rd_valid = rd_req_in; // R17
		if (rd_req_in) begin
			case (rd_addr_in)
				rsf_pkg::ADDR_STREAM_STATUS: begin
					s_d.rd_data = {int_flags, extended_surround_sync_flag_in,
						surround_sync_flag_in, burst_preamble_flag_in,
						chan_status_nonpcm_flag_in, low_byte, 8'h00}; // R2 R3 R4 R5 R6
				end
				rsf_pkg::ADDR_PIN_RATE: begin
					s_d.rd_data = {8'h00, s_q.rate_val, s_q.rate_code,
						s_q.gp_s2 & gp_pin_is_input_in}; // R9 R10 R12
				end
				default: begin
					s_d.rd_data = 24'h000000;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data_out = s_q.rd_data;
	assign rd_valid_out = s_q.rd_valid;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	logic rd_ea;
	logic rd_eb;
	assign rd_ea = rd_req_in && rd_addr_in == rsf_pkg::ADDR_STREAM_STATUS;
	assign rd_eb = rd_req_in && rd_addr_in == rsf_pkg::ADDR_PIN_RATE;

	property p_err_sel;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		rd_ea |=> rd_valid_out && rd_data_out[8] == ($past(error_source_select_in)
			? $past(receive_error_signal_in[1]) : $past(receive_error_signal_in[0]));
	endproperty
	a_err_sel: assert property (p_err_sel) else $error("error bit source wrong"); // R1

	property p_upper;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		rd_ea |=> rd_data_out[19:16] == {$past(extended_surround_sync_flag_in),
			$past(surround_sync_flag_in), $past(burst_preamble_flag_in),
			$past(chan_status_nonpcm_flag_in)};
	endproperty
	a_upper: assert property (p_upper) else $error("upper status byte wrong"); // R2

	property p_i1024;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		rd_ea && surround_sync_flag_in && s_q.interval == 13'h0800
			|=> rd_data_out[23:20] == 4'h6;
	endproperty
	a_i1024: assert property (p_i1024) else $error("interval flags wrong"); // R7

	property p_gp;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		rd_eb |=> rd_data_out[3:0] ==
			($past(gp_pin_in, 3) & $past(gp_pin_is_input_in));
	endproperty
	a_gp: assert property (p_gp) else $error("pin level wrong"); // R9

	property p_code48;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		fs_edge && !step_sat && cnt_step == 8'h80 |=> s_q.rate_code == 4'h9;
	endproperty
	a_code48: assert property (p_code48) else $error("rate code wrong"); // R11

	property p_raw;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		rd_eb |=> rd_data_out[15:8] == $past(s_q.rate_val)
			&& rd_data_out[7:4] == $past(s_q.rate_code);
	endproperty
	a_raw: assert property (p_raw) else $error("rate counter field wrong"); // R12

	property p_tick;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		s_q.ref_tick |=> !s_q.ref_tick;
	endproperty
	a_tick: assert property (p_tick) else $error("reference tick too fast"); // R14

	property p_clr;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		rd_ea && change_event_in == 4'h0 && s_d.rate_code == s_q.rate_code
			|=> s_q.chg == '0;
	endproperty
	a_clr: assert property (p_clr) else $error("flags not cleared by read"); // R16

	property p_sat;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		s_q.rate_sat |-> s_q.rate_code == rsf_pkg::CODE_OUT_OF_RANGE;
	endproperty
	a_sat: assert property (p_sat) else $error("saturated count coded"); // R15

endmodule

`default_nettype wire

// ### tb/rsf_host_model.sv
// Host side of the status bank read port: sets an address, reads the word.
// Assumes the bench calls read_reg; signals move 2 ns after the rising edge.
`default_nettype none

module rsf_host_model (
	input  wire logic        core_clk_in,
	output logic             rd_req_out,
	output logic      [7:0]  rd_addr_out,
	input  wire logic        rd_valid_in,
	input  wire logic [23:0] rd_data_in
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		rd_req_out = 1'b0;
		rd_addr_out = 8'h00;
	end

	// ------------------------------------------------------------
	// One read: address first, then the word comes back
	// ------------------------------------------------------------
	task automatic read_reg(input logic [7:0] a, output logic [23:0] d, output logic ok);
		@(posedge core_clk_in);
		#2;
		rd_req_out = 1'b1;
		rd_addr_out = a;
		@(posedge core_clk_in);
		#2;
		rd_req_out = 1'b0;
		rd_addr_out = ~a;
		ok = rd_valid_in;
		d = rd_data_in;
	endtask
endmodule

`default_nettype wire

// ### tb/rsf_status_bank_tb_top.sv
// Bench for the status bank: stream flags, selects, change flags, pins,
// rate code and counter, sync interval flags. Assumes rsf_host_model.
`default_nettype none

module rsf_status_bank_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk, rst, req, err_sel, aud_sel, emph, cs_np, burst;
	logic        sync51, sync61, frm, sync_fnd, fs_clk, valid;
	logic [1:0]  rx_err, aud_ind;
	logic [3:0]  chg, pins, pin_dir;
	logic [7:0]  addr;
	logic [23:0] rdata;
	int          fails = 0;
	int          checked = 0;

	rsf_status_bank uut (
		.core_clk_in(clk), .sys_rst_in(rst), .rd_addr_in(addr), .rd_req_in(req),
		.receive_error_signal_in(rx_err), .error_source_select_in(err_sel),
		.audio_indication_in(aud_ind), .audio_flag_source_select_in(aud_sel),
		.emphasis_in(emph), .change_event_in(chg), .chan_status_nonpcm_flag_in(cs_np),
		.burst_preamble_flag_in(burst), .surround_sync_flag_in(sync51),
		.extended_surround_sync_flag_in(sync61), .frame_start_in(frm),
		.sync_found_in(sync_fnd), .fs_clk_in(fs_clk), .gp_pin_in(pins),
		.gp_pin_is_input_in(pin_dir), .rd_data_out(rdata), .rd_valid_out(valid)
	);

	rsf_host_model host (
		.core_clk_in(clk), .rd_req_out(req), .rd_addr_out(addr),
		.rd_valid_in(valid), .rd_data_in(rdata)
	);

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input string n, input logic [23:0] s, input logic [23:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [23:0] d);
		logic ok;
		host.read_reg(a, d, ok);
		check("valid", {23'h0, ok}, 24'h1);
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic summarize();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_flags();
		logic [23:0] d;
		for (int i = 0; i < 16; i++) begin
			{sync61, sync51, burst, cs_np} = 4'(i);
			rd(8'hEA, d);
			check("flags", {20'h0, d[19:16]}, 24'(i));
		end
		{sync61, sync51, burst, cs_np} = 4'h0;
		$display("test flags done");
	endtask

	task automatic t_select();
		logic [23:0] d;
		rx_err = 2'b01;
		aud_ind = 2'b10;
		emph = 1'b1;
		for (int s = 0; s < 2; s++) begin
			err_sel = s[0];
			aud_sel = s[0];
			rd(8'hEA, d);
			check("err", {23'h0, d[8]}, {23'h0, rx_err[s]});
			check("nonpcm", {23'h0, d[12]}, {23'h0, aud_ind[s]});
			check("emph", {23'h0, d[15]}, 24'h1);
		end
		emph = 1'b0;
		rd(8'h00, d);
		check("unmapped", d, 24'h0);
		$display("test select done");
	endtask

	task automatic t_change();
		logic [23:0] d;
		int pos [4] = '{9, 11, 13, 14};
		rd(8'hEA, d);
		for (int i = 0; i < 4; i++) begin
			chg = 4'h1 << i;
			step(1);
			chg = 4'h0;
			rd(8'hEA, d);
			check("chg set", {23'h0, d[pos[i]]}, 24'h1);
			rd(8'hEA, d);
			check("chg clear", {23'h0, d[pos[i]]}, 24'h0);
		end
		$display("test change done");
	endtask

	task automatic t_pins();
		logic [23:0] d;
		for (int i = 0; i < 16; i += 5) begin
			pins = 4'(i);
			step(3);
			rd(8'hEB, d);
			check("pins", {20'h0, d[3:0]}, 24'(i));
		end
		pin_dir = 4'h5;
		rd(8'hEB, d);
		check("pin dir", {20'h0, d[3:0]}, 24'h5);
		pin_dir = 4'hF;
		$display("test pins done");
	endtask

	task automatic t_rate();
		logic [23:0] d;
		int per [5] = '{454, 417, 208, 625, 1250};
		logic [3:0] code [5] = '{4'h8, 4'h9, 4'hC, 4'h7, 4'h0};
		int e;
		for (int i = 0; i < 5; i++) begin
			repeat (3) begin
				fs_clk = 1'b1;
				step(per[i] / 2);
				fs_clk = 1'b0;
				step(per[i] - per[i] / 2);
			end
			rd(8'hEB, d);
			e = per[i] * 6144 / 20000;
			check("code", {20'h0, d[7:4]}, {20'h0, code[i]});
			if (e > 255)
				check("count", {16'h0, d[15:8]}, 24'hFF);
			else
				check("count", 24'(d[15:8] >= e - 1 && d[15:8] <= e + 1), 24'h1);
			rd(8'hEA, d);
			check("fs change", {23'h0, d[10]}, 24'h1);
		end
		$display("test rate done");
	endtask

	task automatic t_interval();
		logic [23:0] d;
		int n [5] = '{512, 1024, 2048, 4096, 700};
		logic [3:0] f [5] = '{4'h1, 4'h3, 4'h6, 4'hC, 4'h0};
		sync51 = 1'b1;
		for (int i = 0; i < 5; i++) begin
			repeat (2) begin
				for (int k = 1; k <= n[i]; k++) begin
					frm = 1'b1;
					sync_fnd = (k == n[i]);
					step(1);
					frm = 1'b0;
					sync_fnd = 1'b0;
					step(1);
				end
			end
			rd(8'hEA, d);
			check("interval", {20'h0, d[23:20]}, {20'h0, f[i]});
		end
		sync51 = 1'b0;
		$display("test interval done");
	endtask

	// ------------------------------------------------------------
	// Clock, sequence, watchdog
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		{rx_err, err_sel, aud_ind, aud_sel, emph, chg, cs_np, burst} = '0;
		{sync51, sync61, frm, sync_fnd, fs_clk, pins} = '0;
		pin_dir = 4'hF;
		rst = 1'b1;
		repeat (20) @(posedge clk);
		#2;
		rst = 1'b0;
		t_flags();
		t_select();
		t_change();
		t_pins();
		t_rate();
		t_interval();
		summarize();
	end

	initial begin
		#(80000 * 50);
		fails++;
		$display("watchdog expired");
		summarize();
	end
endmodule

`default_nettype wire
